/* rtl/pam_pkg.sv */
// Purpose: constants and types for the port and alternate function mux
// Assumes: one flat pin vector holding ports 0,1,2,3,4,6 in ascending order
// Notes: subsystem clock pins are kept apart from the flat vector
`default_nettype none
package pam_pkg;
	localparam int PIN_COUNT = 22;
	localparam int ANA_BASE = 10;
	localparam int ANA_W = 4;
	localparam int P30_BIT = 14;
	localparam int P33_BIT = 17;
	localparam int P40_BIT = 18;
	localparam int P41_BIT = 19;
	localparam int P60_BIT = 20;
	localparam int P61_BIT = 21;
	localparam int I2C_W = 2;
	localparam int SUB_W = 2;
	localparam logic [PIN_COUNT-1:0] DIR_RESET = 22'h3FFFFF;
	localparam logic [PIN_COUNT-1:0] LATCH_RESET = 22'h000000;
	localparam logic [PIN_COUNT-1:0] PULL_RESET = 22'h000000;
	localparam logic [PIN_COUNT-1:0] PULLUP_CAP = 22'h3FC3FF;
	localparam logic [ANA_W-1:0] ANA_RESET = 4'h0;
	localparam logic [I2C_W-1:0] I2C_RESET = 2'h0;
	localparam int CTL_RELOC = 0;
	localparam int CTL_ROUTE = 1;
	localparam int CTL_AMP_EN = 2;
	localparam int CTL_GAIN = 3;
	localparam int CTL_XSTART = 4;
	localparam int CTL_EXTSEL = 5;
	localparam int CTL_OSCSEL = 6;
	localparam int CTL_CHAN_LSB = 7;
	localparam int CHAN_W = 2;
	localparam int CTRL_W = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
	typedef enum logic [2:0] {WR_DIR, WR_LATCH, WR_PULL, WR_I2C_IN, WR_I2C_OD, WR_ANALOG, WR_CTRL} pam_reg_t;
	typedef enum logic [1:0] {SUB_PORT, SUB_XTAL, SUB_EXT} pam_sub_mode_t;
endpackage : pam_pkg
`default_nettype wire

/* rtl/pam_port_mux.sv */
// Purpose: pin direction, pull-up, drive mode and alternate function routing
// Assumes: register writes arrive as a strobe, a select and a data word
// Notes: pin drive, enables and read data are registered, one cycle behind state
// Behaviour
// RULE1: per-pin direction bit selects input or output
// RULE2: per-pin pull-up on capable ports
// RULE3: i2c port selects smbus input buffer per bit
// RULE4: i2c port outputs switch to open drain
// RULE5: reset gives inputs; analog port analog
// RULE6: input alternates need direction one
// RULE7: output alternates need direction and latch zero
// RULE8: i2c clock needs direction zero, latch one
// RULE9: route bit puts serial clock on p6/p4
// RULE10: relocation select moves functions off defaults
// RULE11: software sets open drain during i2c
// RULE12: analog pin use set jointly by controls
// RULE13: subsystem clock pins start as input ports
// RULE14: start or osc-select alone gives crystal mode
// RULE15: ext and osc select give external clock
// RULE16: unused subsystem clock pins read as inputs
// RULE17: clock mode bits fixed while clock runs
// RULE18: software waits oscillator stabilisation time
// RULE19: no pin-clocked peripherals without fast clock
// RULE20: reset sets all direction bits to one
// RULE21: read returns pin if input, else latch
`default_nettype none
module pam_port_mux
	import pam_pkg::*;
#(
	parameter int PIN_W = PIN_COUNT
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic wr_en_i,
	input wire pam_reg_t wr_sel_i,
	input wire logic [PIN_W-1:0] wr_data_i,
	input wire logic [PIN_W-1:0] pin_i,
	input wire logic [SUB_W-1:0] sub_pin_i,
	input wire logic timer_out_i,
	input wire logic one_hertz_i,
	input wire logic sck_out_i,
	input wire logic i2c_scl_out_i,
	input wire logic i2c_sda_out_i,
	output logic [PIN_W-1:0] pin_o,
	output logic [PIN_W-1:0] pin_oe_o,
	output logic [PIN_W-1:0] pullup_o,
	output logic [PIN_W-1:0] port_rd_o,
	output logic [SUB_W-1:0] sub_rd_o,
	output logic [I2C_W-1:0] i2c_smbus_o,
	output logic ext_int_o,
	output logic timer_in_o,
	output logic sck_in_o,
	output logic si_reloc_o,
	output logic i2c_scl_in_o,
	output logic i2c_sda_in_o,
	output logic [ANA_W-1:0] adc_connect_o,
	output logic [ANA_W-1:0] amp_connect_o,
	output logic gain_connect_o,
	output logic xtal_en_o,
	output logic ext_clk_en_o
);

	generate
		if (PIN_W != PIN_COUNT)
		begin : g_bad_width
			$error("pin width must match the fixed pin layout");
		end
	endgenerate

	logic [PIN_W-1:0] dir_q;
	logic [PIN_W-1:0] latch_q;
	logic [PIN_W-1:0] pull_q;
	logic [I2C_W-1:0] i2c_in_q;
	logic [I2C_W-1:0] i2c_od_q;
	logic [ANA_W-1:0] ana_cfg_q;
	logic [CTRL_W-1:0] ctrl_q;
	pam_sub_mode_t sub_mode_q;
	pam_sub_mode_t sub_mode_d;
	logic [PIN_W-1:0] alt_or;
	logic [PIN_W-1:0] alt_and;
	logic [PIN_W-1:0] pin_d;
	logic [PIN_W-1:0] oe_d;
	logic [PIN_W-1:0] rd_d;
	logic [ANA_W-1:0] analog_sel;
	logic [ANA_W-1:0] adc_d;
	logic [ANA_W-1:0] amp_d;
	logic [CHAN_W-1:0] chan;
	logic first_q;

	// register writes
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			dir_q <= DIR_RESET; // RULE20 RULE5
			latch_q <= LATCH_RESET;
			pull_q <= PULL_RESET;
		end
		else if (wr_en_i)
		begin
			if (wr_sel_i == WR_DIR)
				dir_q <= wr_data_i; // RULE1
			if (wr_sel_i == WR_LATCH)
				latch_q <= wr_data_i;
			if (wr_sel_i == WR_PULL)
				pull_q <= wr_data_i & PULLUP_CAP; // RULE2
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			i2c_in_q <= I2C_RESET;
			i2c_od_q <= I2C_RESET;
			ana_cfg_q <= ANA_RESET; // RULE5
			ctrl_q <= CTRL_RESET;
		end
		else if (wr_en_i)
		begin
			if (wr_sel_i == WR_I2C_IN)
				i2c_in_q <= wr_data_i[I2C_W-1:0]; // RULE3
			if (wr_sel_i == WR_I2C_OD)
				i2c_od_q <= wr_data_i[I2C_W-1:0]; // RULE4
			if (wr_sel_i == WR_ANALOG)
				ana_cfg_q <= wr_data_i[ANA_W-1:0];
			if (wr_sel_i == WR_CTRL)
				ctrl_q <= wr_data_i[CTRL_W-1:0];
		end
	end

	// subsystem clock pin mode
	always_comb
	begin
		if (ctrl_q[CTL_XSTART])
			sub_mode_d = SUB_XTAL; // RULE14
		else if (!ctrl_q[CTL_EXTSEL] && ctrl_q[CTL_OSCSEL])
			sub_mode_d = SUB_XTAL; // RULE14
		else if (ctrl_q[CTL_EXTSEL] && ctrl_q[CTL_OSCSEL])
			sub_mode_d = SUB_EXT; // RULE15
		else
			sub_mode_d = SUB_PORT; // RULE16
	end

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			sub_mode_q <= SUB_PORT; // RULE13
			xtal_en_o <= 1'b0;
			ext_clk_en_o <= 1'b0;
			sub_rd_o <= '0;
		end
		else
		begin
			sub_mode_q <= sub_mode_d;
			unique case (sub_mode_d)
				SUB_XTAL:
				begin
					xtal_en_o <= 1'b1;
					ext_clk_en_o <= 1'b0;
					sub_rd_o <= '0;
				end
				SUB_EXT:
				begin
					xtal_en_o <= 1'b0;
					ext_clk_en_o <= 1'b1;
					sub_rd_o <= {1'b0, sub_pin_i[0]}; // RULE15
				end
				SUB_PORT:
				begin
					xtal_en_o <= 1'b0;
					ext_clk_en_o <= 1'b0;
					sub_rd_o <= sub_pin_i; // RULE16
				end
				default:
				begin
					xtal_en_o <= 1'b0;
					ext_clk_en_o <= 1'b0;
					sub_rd_o <= '0;
				end
			endcase
		end
	end

	// alternate output merge
	always_comb
	begin
		alt_or = '0;
		alt_and = '1;
		alt_or[P33_BIT] = timer_out_i; // RULE7
		if (!ctrl_q[CTL_RELOC])
			alt_or[P41_BIT] = one_hertz_i; // RULE7 RULE10
		if (ctrl_q[CTL_ROUTE])
		begin
			alt_and[P40_BIT] = sck_out_i; // RULE9
			alt_and[P60_BIT] = i2c_scl_out_i; // RULE8
		end
		else
			alt_and[P60_BIT] = i2c_scl_out_i & sck_out_i; // RULE8 RULE9
		alt_and[P61_BIT] = i2c_sda_out_i;
	end

	// analog pin use
	always_comb
	begin
		chan = ctrl_q[CTL_CHAN_LSB +: CHAN_W];
		analog_sel = ~ana_cfg_q & dir_q[ANA_BASE +: ANA_W]; // RULE12
		adc_d = '0;
		adc_d[chan] = analog_sel[chan]; // RULE12
		amp_d = '0;
		if (ctrl_q[CTL_AMP_EN])
		begin
			amp_d[0] = analog_sel[0];
			amp_d[1] = analog_sel[1] & ~ctrl_q[CTL_GAIN];
			amp_d[2] = analog_sel[2];
		end
	end

	// per-pin drive and read back
	generate
		for (genvar i = 0; i < PIN_W; i++)
		begin : g_pin
			logic val;
			logic od;
			logic dig_in;
			assign val = (latch_q[i] | alt_or[i]) & alt_and[i];
			if (i >= P60_BIT)
			begin : g_i2c
				assign od = i2c_od_q[i-P60_BIT]; // RULE4
			end
			else
			begin : g_norm
				assign od = 1'b0;
			end
			if (i >= ANA_BASE && i < ANA_BASE + ANA_W)
			begin : g_ana
				assign dig_in = pin_i[i] & ana_cfg_q[i-ANA_BASE];
			end
			else
			begin : g_dig
				assign dig_in = pin_i[i];
			end
			assign pin_d[i] = val & ~od;
			assign oe_d[i] = ~dir_q[i] & (~od | ~val); // RULE1 RULE4
			assign rd_d[i] = dir_q[i] ? dig_in : latch_q[i]; // RULE21
		end
	endgenerate

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pin_o <= '0;
			pin_oe_o <= '0;
			pullup_o <= '0;
			port_rd_o <= '0;
			i2c_smbus_o <= '0;
		end
		else
		begin
			pin_o <= pin_d;
			pin_oe_o <= oe_d;
			pullup_o <= pull_q & PULLUP_CAP & dir_q; // RULE2
			port_rd_o <= rd_d;
			i2c_smbus_o <= i2c_in_q; // RULE3
		end
	end

	// alternate inputs to peripherals
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ext_int_o <= 1'b0;
			timer_in_o <= 1'b0;
			sck_in_o <= 1'b0;
			si_reloc_o <= 1'b0;
			i2c_scl_in_o <= 1'b0;
			i2c_sda_in_o <= 1'b0;
			adc_connect_o <= '0;
			amp_connect_o <= '0;
			gain_connect_o <= 1'b0;
		end
		else
		begin
			ext_int_o <= pin_i[P30_BIT] & dir_q[P30_BIT]; // RULE6
			timer_in_o <= pin_i[P33_BIT] & dir_q[P33_BIT]; // RULE6
			sck_in_o <= ctrl_q[CTL_ROUTE] ? pin_i[P40_BIT] : pin_i[P60_BIT]; // RULE9
			si_reloc_o <= ctrl_q[CTL_RELOC] & pin_i[P41_BIT]; // RULE10
			i2c_scl_in_o <= pin_i[P60_BIT];
			i2c_sda_in_o <= pin_i[P61_BIT];
			adc_connect_o <= adc_d;
			amp_connect_o <= amp_d;
			gain_connect_o <= analog_sel[1] & ctrl_q[CTL_AMP_EN] & ctrl_q[CTL_GAIN]; // RULE12
		end
	end

	// helper: marks the first edge after reset release
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			first_q <= 1'b0;
		else
			first_q <= 1'b1;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	sequence smbus_write_s;
		wr_en_i && wr_sel_i == WR_I2C_IN;
	endsequence

	sequence ext_request_s;
		!ctrl_q[CTL_XSTART] && ctrl_q[CTL_EXTSEL] && ctrl_q[CTL_OSCSEL];
	endsequence

	dir_no_drive_a: assert property ((pin_oe_o & $past(dir_q)) == '0) // RULE1
		else $error("input pin driven");
	pullup_cap_a: assert property ((pullup_o & ~PULLUP_CAP) == '0) // RULE2
		else $error("pull-up on incapable pin");
	smbus_select_a: assert property (smbus_write_s |=> ##1 i2c_smbus_o == $past(wr_data_i[I2C_W-1:0], 2)) // RULE3
		else $error("smbus select not applied");
	open_drain_high_a: assert property ($past(i2c_od_q[1]) |-> !pin_o[P61_BIT]) // RULE4
		else $error("open drain pin driven high");
	reset_state_a: assert property (!first_q |-> dir_q == DIR_RESET && ana_cfg_q == ANA_RESET && sub_mode_q == SUB_PORT) // RULE5
		else $error("wrong state after reset");
	crystal_mode_a: assert property (ctrl_q[CTL_XSTART] |=> xtal_en_o && !ext_clk_en_o) // RULE14
		else $error("crystal mode missed");
	ext_clock_a: assert property (ext_request_s ##1 ext_request_s |-> ext_clk_en_o && !xtal_en_o && sub_rd_o[1] == 1'b0) // RULE15
		else $error("external clock mode missed");
	sck_route_a: assert property (ctrl_q[CTL_ROUTE] |=> sck_in_o == $past(pin_i[P40_BIT])) // RULE9
		else $error("serial clock not routed to port 4");
	read_latch_a: assert property (!dir_q[0] |=> port_rd_o[0] == $past(latch_q[0])) // RULE21
		else $error("output pin read mismatch");

endmodule : pam_port_mux
`default_nettype wire

/* test/pam_board.sv */
// Purpose: board side of the port pins
// Assumes: the board drives every pad that the device leaves released
// Notes: new board levels on each step pulse
`default_nettype none
module pam_board
	import pam_pkg::*;
(
	input wire logic clock_i,
	input wire logic step_i,
	input wire logic [PIN_COUNT-1:0] pin_o_i,
	input wire logic [PIN_COUNT-1:0] pin_oe_i,
	output logic [PIN_COUNT-1:0] pin_i_o,
	output logic [SUB_W-1:0] sub_pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	integer seed = 67000;
	logic [PIN_COUNT-1:0] ext_q = '0;
	logic [SUB_W-1:0] sub_q = '0;
	always @(posedge clock_i)
		if (step_i)
		begin
			ext_q <= PIN_COUNT'($random(seed));
			sub_q <= SUB_W'($random(seed));
		end
	assign sub_pin_o = sub_q;
	// pad drive wins, else board level
	assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_q);
endmodule : pam_board
`default_nettype wire

/* test/tb_top.sv */
// Purpose: random checks of the port and alternate function mux
// Assumes: outputs settle within four edges of a change
// Notes: expectations come from shadow copies of all writes
`default_nettype none
module tb_top
	import pam_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i, reset_n_i, wr_en_i, step, timer_out_i, one_hertz_i, sck_out_i, i2c_scl_out_i, i2c_sda_out_i;
	pam_reg_t wr_sel_i;
	logic [21:0] wr_data_i, pin_i, pin_o, pin_oe_o, pullup_o, port_rd_o, dir, lat, pul;
	logic [1:0] sub_pin_i, sub_rd_o, i2c_smbus_o, smb, od;
	logic [3:0] adc_connect_o, amp_connect_o, ana;
	logic ext_int_o, timer_in_o, sck_in_o, si_reloc_o, i2c_scl_in_o, i2c_sda_in_o, gain_connect_o;
	logic xtal_en_o, ext_clk_en_o;
	logic [8:0] ctl;
	integer seed = 67000;
	int num_errors = 0;
	int compares = 0;
	pam_port_mux pam_port_mux_i (.clock_i, .reset_n_i, .wr_en_i, .wr_sel_i, .wr_data_i, .pin_i, .sub_pin_i,
		.timer_out_i, .one_hertz_i, .sck_out_i, .i2c_scl_out_i, .i2c_sda_out_i, .pin_o, .pin_oe_o,
		.pullup_o, .port_rd_o, .sub_rd_o, .i2c_smbus_o, .ext_int_o, .timer_in_o, .sck_in_o, .si_reloc_o,
		.i2c_scl_in_o, .i2c_sda_in_o, .adc_connect_o, .amp_connect_o, .gain_connect_o, .xtal_en_o,
		.ext_clk_en_o);
	pam_board pam_board_i (.clock_i, .step_i(step), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pin_i_o(pin_i),
		.sub_pin_o(sub_pin_i));
	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	task automatic close_out();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	task automatic chk(logic [21:0] s, logic [21:0] e);
		compares++;
		if (s !== e)
		begin
			num_errors++;
			$display("ERROR %0t: got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(pam_reg_t s, logic [21:0] d);
		@(posedge clock_i);
		wr_en_i <= 1'b1;
		wr_sel_i <= s;
		wr_data_i <= d;
		@(posedge clock_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task automatic check_all();
		logic [21:0] eo, eoe, erd;
		logic [3:0] ea, em;
		logic [1:0] ch, ei;
		logic xs, es, eg;
		repeat (4) @(posedge clock_i);
		#1;
		eo = lat;
		eo[P33_BIT] |= timer_out_i;
		if (!ctl[CTL_RELOC])
			eo[P41_BIT] |= one_hertz_i;
		if (ctl[CTL_ROUTE])
			eo[P40_BIT] &= sck_out_i;
		else
			eo[P60_BIT] &= sck_out_i;
		eo[P60_BIT] &= i2c_scl_out_i;
		eo[P61_BIT] &= i2c_sda_out_i;
		eoe = ~dir;
		erd = (dir & pin_i) | (~dir & lat);
		for (int k = 0; k < 2; k++)
			if (od[k])
			begin
				eoe[P60_BIT+k] &= ~eo[P60_BIT+k];
				eo[P60_BIT+k] = 1'b0;
			end
		for (int k = 0; k < ANA_W; k++)
			if (!ana[k] && dir[ANA_BASE+k])
				erd[ANA_BASE+k] = 1'b0;
		ch = ctl[CTL_CHAN_LSB +: CHAN_W];
		ea = (!ana[ch] && dir[ANA_BASE+ch]) ? 4'h1 << ch : 4'h0;
		em = ctl[CTL_AMP_EN] ? {1'h0, ~ana[2:0] & dir[ANA_BASE +: 3]} : 4'h0;
		if (ctl[CTL_GAIN])
			em[1] = 1'b0;
		eg = ~ana[1] & dir[ANA_BASE+1] & ctl[CTL_AMP_EN] & ctl[CTL_GAIN];
		xs = ctl[CTL_XSTART] | (~ctl[CTL_EXTSEL] & ctl[CTL_OSCSEL]);
		es = ~ctl[CTL_XSTART] & ctl[CTL_EXTSEL] & ctl[CTL_OSCSEL];
		chk(pin_oe_o, eoe);
		chk(pin_o, eo);
		chk(port_rd_o, erd);
		chk(pullup_o, pul & PULLUP_CAP & dir);
		chk(22'(i2c_smbus_o), 22'(smb));
		ei = {pin_i[P30_BIT] & dir[P30_BIT], pin_i[P33_BIT] & dir[P33_BIT]};
		chk(22'({ext_int_o, timer_in_o}), 22'(ei));
		ei = {pin_i[ctl[CTL_ROUTE] ? P40_BIT : P60_BIT], ctl[CTL_RELOC] & pin_i[P41_BIT]};
		chk(22'({sck_in_o, si_reloc_o}), 22'(ei));
		chk(22'({i2c_scl_in_o, i2c_sda_in_o}), 22'({pin_i[P60_BIT], pin_i[P61_BIT]}));
		chk(22'({adc_connect_o, amp_connect_o, gain_connect_o}), 22'({ea, em, eg}));
		chk(22'({xtal_en_o, ext_clk_en_o}), 22'({xs, es}));
		chk(22'(sub_rd_o), 22'(xs ? 2'h0 : es ? {1'h0, sub_pin_i[0]} : sub_pin_i));
	endtask : check_all
	task automatic do_reset(int n);
		reset_n_i <= 0;
		repeat (n) @(posedge clock_i);
		reset_n_i <= 1;
		dir = DIR_RESET;
		{lat, pul, smb, od, ana, ctl} = '0;
		check_all();
	endtask : do_reset
	initial
	begin
		{reset_n_i, wr_en_i, step, timer_out_i, one_hertz_i, i2c_scl_out_i, i2c_sda_out_i} = '0;
		sck_out_i = 1;
		wr_sel_i = WR_DIR;
		wr_data_i = '0;
		do_reset(16);
		for (int i = 0; i < 48; i++)
		begin
			dir = 22'($random(seed));
			lat = 22'($random(seed));
			pul = 22'($random(seed));
			smb = 2'($random(seed));
			od = 2'($random(seed));
			ana = 4'($random(seed));
			ctl = 9'($random(seed));
			ctl[CTL_XSTART +: 3] = i[2:0];
			wr(WR_CTRL, '0);
			wr(WR_DIR, dir);
			wr(WR_LATCH, lat);
			wr(WR_PULL, pul);
			wr(WR_I2C_IN, smb);
			wr(WR_I2C_OD, od);
			wr(WR_ANALOG, ana);
			wr(WR_CTRL, ctl);
			wr(pam_reg_t'(3'h7), '1);
			{timer_out_i, one_hertz_i, sck_out_i, i2c_scl_out_i, i2c_sda_out_i} <= 5'($random(seed));
			step <= 1;
			@(posedge clock_i);
			step <= 0;
			check_all();
		end
		@(posedge clock_i);
		do_reset(1);
		close_out();
	end
	initial
	begin
		#250000;
		num_errors++;
		close_out();
	end
endmodule : tb_top
`default_nettype wire
